// [bmfpf_pkg.sv]
// Shared constants and types for the bus-matching FIFO port logic
package bmfpf_pkg;

	localparam int DATA_W        = 36;
	localparam int WORD_W        = 18;
	localparam int BYTE_W        = 9;
	localparam int DEPTH_DEFAULT = 256;
	localparam int BUF_ENTRIES   = 2;

	localparam logic [DATA_W-1:0] DATA_RESET = 36'h0_0000_0000;
	localparam logic [1:0]        OCC_EMPTY  = 2'h0;
	localparam logic [1:0]        OCC_ONE    = 2'h1;
	localparam logic [1:0]        OCC_FULL   = 2'h2;
	localparam logic [1:0]        PIECE_ZERO = 2'h0;
	localparam logic [1:0]        PIECE_ONE  = 2'h1;
	localparam logic [1:0]        LAST_LONG  = 2'h0;
	localparam logic [1:0]        LAST_WORD  = 2'h1;
	localparam logic [1:0]        LAST_BYTE  = 2'h3;

	typedef logic [DATA_W-1:0] bmfpf_data_type;

	// Port B bus width as latched at master reset
	typedef enum logic [1:0] {
		BMFPF_LONG,
		BMFPF_WORD,
		BMFPF_BYTE
	} bmfpf_width_type;

endpackage

// [bmfpf_mem.sv]
// Dual-port storage array with registered read data
`timescale 1ns/1ps
module bmfpf_mem #(
	parameter int DW    = 36,
	parameter int DEPTH = 256,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic          clk,
	input  wire logic          wrEn,
	input  wire logic [AW-1:0] wrAddr,
	input  wire logic [DW-1:0] wrData,
	input  wire logic          rdEn,
	input  wire logic [AW-1:0] rdAddr,
	output logic      [DW-1:0] rdData
);

	logic [DW-1:0] ram [DEPTH];

	if (DEPTH < 2 || AW != $clog2(DEPTH)) begin : gDepthCheck
		$error("bmfpf_mem: AW must match DEPTH");
	end

	always_ff @(posedge clk) begin
		if (wrEn) begin
			ram[wrAddr] <= wrData;
		end
		if (rdEn) begin
			rdData <= ram[rdAddr];
		end
	end

endmodule // bmfpf_mem

// [bmfpf_skid.sv]
// Two-entry buffer between the array and the Port B unpacker
`timescale 1ns/1ps
module bmfpf_skid
	import bmfpf_pkg::*;
#(
	parameter int DW = 36
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          inValid,
	output logic               inReady,
	input  wire logic [DW-1:0] inData,
	output logic               outValid,
	input  wire logic          outReady,
	output logic      [DW-1:0] outData,
	output logic      [1:0]    occupancy
);

	typedef struct packed {
		logic [DW-1:0] head;
		logic [DW-1:0] tail;
		logic [1:0]    occ;
	} bmfpf_skid_type;

	bmfpf_skid_type s;
	bmfpf_skid_type next_s;
	logic           push;
	logic           pop;

	assign inReady   = (s.occ != OCC_FULL);
	assign outValid  = (s.occ != OCC_EMPTY);
	assign outData   = s.head;
	assign occupancy = s.occ;
	assign push      = inValid & inReady;
	assign pop       = outValid & outReady;

	always_comb begin
		next_s = s;
		if (pop) begin
			next_s.head = s.tail;
		end
		if (push) begin
			// Slot that the new word lands in after any pop
			if ((s.occ == OCC_EMPTY) || ((s.occ == OCC_ONE) && pop)) begin
				next_s.head = inData;
			end else begin
				next_s.tail = inData;
			end
		end
		if (push && !pop) begin
			next_s.occ = s.occ + OCC_ONE;
		end else if (pop && !push) begin
			next_s.occ = s.occ - OCC_ONE;
		end
		if (!rst_n) begin
			next_s.occ = OCC_EMPTY;
		end
	end

	always_ff @(posedge clk) begin
		s <= next_s;
	end

endmodule // bmfpf_skid

// [bmfpf_top.sv]
// Bus-matching FIFO: port logic, flags, endian and width selection
`timescale 1ns/1ps
// Functional notes
// - Almost-empty flag low when stored count is at or below offset X.
// - Almost-full flag low when free locations are at or below offset Y.
// - Select pin high at reset: most significant piece leaves Port B first.
// - Select pin low at reset: least significant piece leaves Port B first.
// - After reset the same pin picks timing: high standard, low fall-through.
// - Width match low gives long word; high gives byte or word by size.
// - Port A is a 36-bit two-way data port; here a Port A read drives zero.
// - Port B is a 36-bit two-way data port for reading contents; here portBDataIn is unused.
// - Port A transfers and its flags act on the rising Port A edge.
// - Port B transfers and its flags act on the rising Port B edge.
// - Port clocks may be unrelated or coincident; here one clock serves both ports.
// - Port A transfer needs its select low on the clock edge.
// - Port A data outputs float while its select is high.
// - Port B transfer needs its select low on the clock edge.
// - Port B data outputs float while its select is high.
// - Standard mode: Port B status is the empty flag.
// - Fall-through mode: Port B status is output-ready for valid data.
// - Port A transfer also needs its enable high.
// - Port A status is full in standard mode, input-ready in fall-through.
module bmfpf_top
	import bmfpf_pkg::*;
#(
	parameter int DEPTH = DEPTH_DEFAULT,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       endian_timing_select,
	input  wire logic                       port_b_width_match,
	input  wire logic                       portBSizeByte,
	input  wire logic [AW:0]                almostEmptyOffset,
	input  wire logic [AW:0]                almostFullOffset,
	input  wire logic                       port_a_select_n,
	input  wire logic                       port_a_enable,
	input  wire logic                       portAWrite,
	input  wire bmfpf_pkg::bmfpf_data_type  portADataIn,
	output bmfpf_pkg::bmfpf_data_type       portADataOut,
	output logic                            portADataOe_n,
	input  wire logic                       port_b_select_n,
	input  wire logic                       portBEnable,
	input  wire logic                       portBRead,
	input  wire bmfpf_pkg::bmfpf_data_type  portBDataIn,
	output bmfpf_pkg::bmfpf_data_type       portBDataOut,
	output logic                            portBDataOe_n,
	output logic                            full_or_input_ready,
	output logic                            almost_full_flag_n,
	output logic                            empty_or_output_ready,
	output logic                            almost_empty_flag_n
);

	localparam logic [AW:0] DEPTH_COUNT = (AW + 1)'(DEPTH);
	localparam logic [AW:0] COUNT_ONE   = (AW + 1)'(1);

	if (DEPTH < 4 || (1 << AW) != DEPTH || AW != $clog2(DEPTH)) begin : gDepthCheck
		$error("bmfpf_top: DEPTH must be a power of two, at least 4, with matching AW");
	end

	// Piece slicing assumes two words or four bytes per long word
	if (DATA_W != 2 * WORD_W || DATA_W != 4 * BYTE_W) begin : gWidthCheck
		$error("bmfpf_top: piece widths must divide the long word exactly");
	end

	typedef struct packed {
		logic [AW:0]     wrPtr;
		logic [AW:0]     rdPtr;
		logic [AW:0]     retPtr;
		logic            pend;
		logic            outValid;
		logic [1:0]      piece;
		bmfpf_data_type  outData;
		logic            bigEndian;
		bmfpf_width_type width;
	} bmfpf_state_type;

	bmfpf_state_type s;
	bmfpf_state_type next_s;

	logic           fallThrough;
	logic [AW:0]    count;
	logic [AW:0]    freeCount;
	logic           isFull;
	logic           doWrite;
	logic           readReq;
	logic           issue;
	logic           load;
	logic           lastPiece;
	logic [1:0]     occ;
	logic           bufInReady;
	logic           bufOutValid;
	logic           bufOutReady;
	bmfpf_data_type bufOutData;
	bmfpf_data_type memRdData;

	// Index of the last piece for a bus width
	function automatic logic [1:0] lastIndex(input bmfpf_width_type w);
		unique case (w)
			BMFPF_LONG: lastIndex = LAST_LONG;
			BMFPF_WORD: lastIndex = LAST_WORD;
			BMFPF_BYTE: lastIndex = LAST_BYTE;
			default:    lastIndex = LAST_LONG;
		endcase
	endfunction

	// Piece of a long word in transfer order, right aligned
	function automatic bmfpf_data_type pickPiece(
		input bmfpf_data_type  w,
		input bmfpf_width_type wd,
		input logic            big,
		input logic [1:0]      p
	);
		logic [1:0] e;
		e = big ? (lastIndex(wd) - p) : p;
		unique case (wd)
			BMFPF_LONG: pickPiece = w;
			BMFPF_WORD: pickPiece = DATA_W'(w[int'(e[0]) * WORD_W +: WORD_W]);
			BMFPF_BYTE: pickPiece = DATA_W'(w[int'(e) * BYTE_W +: BYTE_W]);
			default:    pickPiece = w;
		endcase
	endfunction

	// Partial flag level: high while the value is above its offset
	function automatic logic aboveMark(
		input logic [AW:0] value,
		input logic [AW:0] mark
	);
		aboveMark = (value > mark);
	endfunction

	// Timing mode follows the pin live once reset is released
	// pin selects timing
	assign fallThrough = ~endian_timing_select;

	assign count     = s.wrPtr - s.retPtr;
	assign freeCount = DEPTH_COUNT - count;
	assign isFull    = (count == DEPTH_COUNT);

	assign doWrite = ~port_a_select_n & port_a_enable & portAWrite & ~isFull;

	assign readReq = ~port_b_select_n & portBEnable & portBRead;

	// Prefetch only while the buffer has a slot for the word in flight
	assign issue = (s.wrPtr != s.rdPtr) && rst_n && bufInReady &&
		((occ == OCC_EMPTY) || ((occ == OCC_ONE) && !s.pend));

	assign lastPiece = (s.piece == lastIndex(s.width));

	assign load = bufOutValid && rst_n &&
		(fallThrough ? (!s.outValid || readReq) : readReq);

	assign bufOutReady = load & lastPiece;

	bmfpf_mem #(
		.DW    (DATA_W),
		.DEPTH (DEPTH),
		.AW    (AW)
	) uMem (
		.clk    (clk),
		.wrEn   (doWrite),
		.wrAddr (s.wrPtr[AW-1:0]),
		.wrData (portADataIn),
		.rdEn   (issue),
		.rdAddr (s.rdPtr[AW-1:0]),
		.rdData (memRdData)
	);

	bmfpf_skid #(
		.DW (DATA_W)
	) uSkid (
		.clk       (clk),
		.rst_n     (rst_n),
		.inValid   (s.pend),
		.inReady   (bufInReady),
		.inData    (memRdData),
		.outValid  (bufOutValid),
		.outReady  (bufOutReady),
		.outData   (bufOutData),
		.occupancy (occ)
	);

	always_comb begin
		next_s      = s;
		next_s.pend = issue;
		if (doWrite) begin
			next_s.wrPtr = s.wrPtr + COUNT_ONE;
		end
		if (issue) begin
			next_s.rdPtr = s.rdPtr + COUNT_ONE;
		end
		if (load) begin
			next_s.outData  = pickPiece(bufOutData, s.width, s.bigEndian, s.piece);
			next_s.outValid = 1'b1;
			next_s.piece    = lastPiece ? PIECE_ZERO : (s.piece + PIECE_ONE);
			if (lastPiece) begin
				next_s.retPtr = s.retPtr + COUNT_ONE;
			end
		end else if (fallThrough && readReq) begin
			next_s.outValid = 1'b0;
		end
		if (!rst_n) begin
			next_s.wrPtr    = '0;
			next_s.rdPtr    = '0;
			next_s.retPtr   = '0;
			next_s.pend     = 1'b0;
			next_s.outValid = 1'b0;
			next_s.piece    = PIECE_ZERO;
			next_s.outData  = DATA_RESET;
			// Configuration caught while master reset is held
			next_s.bigEndian = endian_timing_select;
			if (!port_b_width_match) begin
				next_s.width = BMFPF_LONG;
			end else if (portBSizeByte) begin
				next_s.width = BMFPF_BYTE;
			end else begin
				next_s.width = BMFPF_WORD;
			end
		end
	end

	// coincident port clocks
	// One clock serves both ports, so flags need no synchronisers
	always_ff @(posedge clk) begin
		s <= next_s;
	end

	// Port A data
	// Port A has no readable source here; it drives zero when read
	assign portADataOut = DATA_RESET;
	assign portADataOe_n = port_a_select_n | portAWrite;

	assign portBDataOut = s.outData;
	assign portBDataOe_n = port_b_select_n | ~portBRead;

	assign full_or_input_ready = ~isFull;

	assign almost_full_flag_n = aboveMark(freeCount, almostFullOffset);

	assign empty_or_output_ready = fallThrough ? s.outValid : bufOutValid;

	assign almost_empty_flag_n = aboveMark(count, almostEmptyOffset);

endmodule // bmfpf_top

// [bmfpf_monitor.sv]
// Port-level checker for the bus-matching FIFO
`timescale 1ns/1ps
module bmfpf_monitor (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        endian_timing_select,
	input wire logic        port_a_select_n,
	input wire logic        port_a_enable,
	input wire logic        portAWrite,
	input wire logic        portADataOe_n,
	input wire logic        port_b_select_n,
	input wire logic        portBEnable,
	input wire logic        portBRead,
	input wire logic        portBDataOe_n,
	input wire logic [35:0] portBDataOut,
	input wire logic        full_or_input_ready,
	input wire logic        almost_full_flag_n,
	input wire logic        empty_or_output_ready,
	input wire logic        almost_empty_flag_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic wrReq;
	logic rdReq;
	assign wrReq = !port_a_select_n && port_a_enable && portAWrite && full_or_input_ready;
	assign rdReq = !port_b_select_n && portBEnable && portBRead;
	sequence ftIdle;
		!endian_timing_select && empty_or_output_ready && !rdReq;
	endsequence
	sequence ftHeld;
		empty_or_output_ready && $stable(portBDataOut);
	endsequence
	a_port_a_float: assert property (port_a_select_n |-> portADataOe_n)
		else $error("port A driven while deselected");
	a_port_b_drive: assert property (portBDataOe_n == (port_b_select_n || !portBRead))
		else $error("port B enable wrong");
	a_reset_state: assert property ($rose(rst_n) |-> full_or_input_ready && !empty_or_output_ready
		&& !almost_empty_flag_n && portBDataOut == bmfpf_pkg::DATA_RESET) else $error("bad state after reset");
	a_full_needs_write: assert property ($fell(full_or_input_ready) |-> $past(wrReq))
		else $error("full without write");
	a_low_mark_write: assert property ($rose(almost_empty_flag_n) |-> $past(wrReq))
		else $error("almost empty cleared without write");
	a_high_mark_read: assert property (endian_timing_select && $rose(almost_full_flag_n) |-> $past(rdReq))
		else $error("almost full cleared without read");
	a_std_data_hold: assert property (endian_timing_select && !rdReq |=> $stable(portBDataOut))
		else $error("port B data moved without read");
	a_ft_ready_hold: assert property (ftIdle |=> ftHeld)
		else $error("ready word lost without read");
endmodule // bmfpf_monitor

// [bmfpf_reader.sv]
// Port B reader model with a never-idle data bus
`timescale 1ns/1ps
module bmfpf_reader (
	input  wire logic           clk,
	input  wire logic           rdReq,
	output logic                port_b_select_n,
	output logic                portBEnable,
	output logic                portBRead,
	output bmfpf_pkg::bmfpf_data_type portBDataIn
);
	import bmfpf_pkg::*;
	assign port_b_select_n = !rdReq;
	assign portBEnable     = rdReq;
	assign portBRead       = rdReq;
	bmfpf_data_type busWord = 36'h5_5555_5555;
	assign portBDataIn = busWord;
	// Unused bus toggles each cycle
	always @(posedge clk) busWord <= ~busWord;
endmodule // bmfpf_reader

// [bmfpf_tb_top.sv]
// Self-checking bench for the bus-matching FIFO
`timescale 1ns/1ps
module bmfpf_tb_top;
	import bmfpf_pkg::*;
	logic           clk = 1'b0;
	logic           rst_n, endian_timing_select, port_b_width_match, portBSizeByte, rdReq;
	logic [4:0]     almostEmptyOffset, almostFullOffset;
	logic           port_a_select_n, port_a_enable, portAWrite, port_b_select_n, portBEnable, portBRead;
	logic           portADataOe_n, portBDataOe_n, full_or_input_ready, almost_full_flag_n;
	logic           empty_or_output_ready, almost_empty_flag_n;
	bmfpf_data_type portADataIn, portADataOut, portBDataIn, portBDataOut;
	int             fail_count = 0;
	int             check_count = 0;
	always #5 clk = ~clk;
	bmfpf_top #(.DEPTH(16)) u_bmfpf_top (.clk, .rst_n, .endian_timing_select, .port_b_width_match,
		.portBSizeByte, .almostEmptyOffset, .almostFullOffset, .port_a_select_n, .port_a_enable,
		.portAWrite, .portADataIn, .portADataOut, .portADataOe_n, .port_b_select_n, .portBEnable,
		.portBRead, .portBDataIn, .portBDataOut, .portBDataOe_n, .full_or_input_ready,
		.almost_full_flag_n, .empty_or_output_ready, .almost_empty_flag_n);
	bmfpf_reader u_bmfpf_reader (.clk, .rdReq, .port_b_select_n, .portBEnable, .portBRead, .portBDataIn);
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chkData(bmfpf_data_type got, bmfpf_data_type exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected data at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic chkBit(logic got, logic exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected flag at %0t: %b not %b", $time, got, exp);
		end
	endtask
	task automatic doReset(logic big, logic match, logic sz, logic tm);
		@(posedge clk);
		rst_n <= 1'b0;
		endian_timing_select <= big;
		port_b_width_match <= match;
		portBSizeByte <= sz;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		// timing pin held static after this
		endian_timing_select <= tm;
		@(posedge clk);
		#1;
	endtask
	task automatic writeWords(int n, bmfpf_data_type base, logic en);
		@(posedge clk);
		port_a_select_n <= 1'b0;
		port_a_enable <= en;
		portAWrite <= 1'b1;
		for (int i = 0; i < n; i++) begin
			portADataIn <= base + 36'(i);
			@(posedge clk);
		end
		port_a_select_n <= 1'b1;
		port_a_enable <= 1'b0;
		portAWrite <= 1'b0;
		#1;
	endtask
	task automatic readPiece(logic ft, bmfpf_data_type exp);
		int n;
		n = 0;
		while (empty_or_output_ready !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 50) begin
				fail_count++;
				$display("unexpected hang at %0t", $time);
				stop_test();
			end
		end
		if (ft)
			chkData(portBDataOut, exp);
		@(posedge clk);
		rdReq <= 1'b1;
		@(posedge clk);
		rdReq <= 1'b0;
		#1;
		if (!ft)
			chkData(portBDataOut, exp);
	endtask
	task automatic tStd();
		doReset(1'b0, 1'b0, 1'b0, 1'b1);
		chkBit(full_or_input_ready, 1'b1);
		chkBit(almost_empty_flag_n, 1'b0);
		chkBit(almost_full_flag_n, 1'b1);
		chkBit(portADataOe_n, 1'b1);
		writeWords(1, 36'hF_FFFF_FFFF, 1'b0);
		repeat (5) @(posedge clk);
		#1;
		chkBit(empty_or_output_ready, 1'b0);
		@(posedge clk);
		port_a_enable <= 1'b1;
		portAWrite <= 1'b1;
		@(posedge clk);
		port_a_enable <= 1'b0;
		portAWrite <= 1'b0;
		repeat (5) @(posedge clk);
		#1;
		chkBit(empty_or_output_ready, 1'b0);
		@(posedge clk);
		port_a_select_n <= 1'b0;
		@(posedge clk);
		#1;
		chkBit(portADataOe_n, 1'b0);
		chkData(portADataOut, 36'h0_0000_0000);
		@(posedge clk);
		port_a_select_n <= 1'b1;
		writeWords(17, 36'h9_0000_0A00, 1'b1);
		chkBit(full_or_input_ready, 1'b0);
		chkBit(almost_full_flag_n, 1'b0);
		chkBit(almost_empty_flag_n, 1'b1);
		for (int i = 0; i < 16; i++)
			readPiece(1'b0, 36'h9_0000_0A00 + 36'(i));
		repeat (5) @(posedge clk);
		#1;
		chkBit(empty_or_output_ready, 1'b0);
		chkBit(almost_empty_flag_n, 1'b0);
		chkBit(full_or_input_ready, 1'b1);
		$display("standard long test done");
	endtask
	task automatic tFall(logic big, logic sz);
		bmfpf_data_type w;
		int wid;
		int cnt;
		int sh;
		w = 36'hA_5C3E_9712;
		wid = sz ? 9 : 18;
		cnt = sz ? 4 : 2;
		doReset(big, 1'b1, sz, 1'b0);
		writeWords(1, w, 1'b1);
		for (int k = 0; k < cnt; k++) begin
			sh = big ? (cnt - 1 - k) * wid : k * wid;
			readPiece(1'b1, (w >> sh) & ((36'h1 << wid) - 36'h1));
		end
		chkBit(empty_or_output_ready, 1'b0);
		$display("fall-through test big=%b byte=%b done", big, sz);
	endtask
	initial begin
		rst_n = 1'b0;
		endian_timing_select = 1'b0;
		port_b_width_match = 1'b0;
		portBSizeByte = 1'b0;
		almostEmptyOffset = 5'h02;
		almostFullOffset = 5'h03;
		port_a_select_n = 1'b1;
		port_a_enable = 1'b0;
		portAWrite = 1'b0;
		portADataIn = 36'h0_0000_0000;
		rdReq = 1'b0;
		tStd();
		tFall(1'b1, 1'b1);
		tFall(1'b0, 1'b1);
		tFall(1'b1, 1'b0);
		tFall(1'b0, 1'b0);
		stop_test();
	end
endmodule // bmfpf_tb_top
bind bmfpf_top bmfpf_monitor u_bmfpf_monitor (.clk, .rst_n, .endian_timing_select, .port_a_select_n,
	.port_a_enable, .portAWrite, .portADataOe_n, .port_b_select_n, .portBEnable, .portBRead, .portBDataOe_n,
	.portBDataOut, .full_or_input_ready, .almost_full_flag_n, .empty_or_output_ready, .almost_empty_flag_n);
